// ===== logic/addr_calc_if.sv
// Purpose: Carrier between the decoder and its address calculator
// Assumes: One clock domain, purely combinational calculator
// Notes:   None

`default_nettype none

interface addr_calc_if;
   import addr_decode_pkg::*;

   logic [OPER_W-1:0] operand;
   logic              access_bit;
   logic              ext_enable;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] pointer;
   logic [ADDR_W-1:0] addr;
   logic              indexed;

   modport requester (output operand, access_bit, ext_enable, bank, pointer,
                      input  addr, indexed);
   modport calc      (input  operand, access_bit, ext_enable, bank, pointer,
                      output addr, indexed);
endinterface

`default_nettype wire

// ===== logic/addr_decode_pkg.sv
// Purpose: Shared constants for file-address decode of byte and bit instructions
// Assumes: 12-bit data address space, 16-bit instruction words
// Notes:   Access bit, destination bit and opcode field positions are named here only once

`default_nettype none

package addr_decode_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W  = 12;
   localparam int BANK_W  = 4;
   localparam int OPER_W  = 8;
   localparam int INSTR_W = 16;

   // ----------------------------------------------------------------
   // Field positions inside the instruction word
   // ----------------------------------------------------------------
   localparam int A_BIT   = 8;
   localparam int D_BIT   = 9;
   localparam int OP_HI   = 15;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [OPER_W-1:0] OFFSET_LIMIT = 8'h5F;
   localparam logic [OPER_W-1:0] ACCESS_SPLIT = 8'h80;
   localparam logic [BANK_W-1:0] LOW_BANK     = 4'h0;
   localparam logic [BANK_W-1:0] SFR_BANK     = 4'hF;
   localparam logic [BANK_W-1:0] ZERO_BANK    = 4'h0;
   localparam logic [ADDR_W-1:0] ZERO_ADDR    = 12'h000;
   localparam logic [OPER_W-1:0] ZERO_BYTE    = 8'h00;

   // ----------------------------------------------------------------
   // Opcode classes that carry the access select bit
   // ----------------------------------------------------------------
   localparam logic [3:0] OP_FILE_FIRST = 4'h1;
   localparam logic [3:0] OP_FILE_LAST  = 4'hB;
   localparam logic [3:0] OP_BIT_FIRST  = 4'h7;
   localparam logic [6:0] OP_MUL_FILE   = 7'h01;
   localparam logic [5:0] OP_DEC_FILE   = 6'h01;
   localparam logic [5:0] OP_XOR_FILE   = 6'h06;

endpackage

`default_nettype wire

// ===== logic/file_addr_calc.sv
// Purpose: Map a file operand to a data-memory address
// Assumes: Inputs stable for the cycle in which they are used
// Notes:   Combinational; the decoder registers the result

`default_nettype none

module file_addr_calc
   import addr_decode_pkg::*;
(
   addr_calc_if.calc io
);

   always_comb begin
      // Only low operands with the access bit clear become offsets
      io.indexed = io.ext_enable && !io.access_bit
                   && (io.operand <= OFFSET_LIMIT);
      if (io.indexed) begin
         io.addr = io.pointer + {ZERO_BANK, io.operand};
      end else if (io.access_bit) begin
         io.addr = {io.bank, io.operand};
      end else if (io.operand < ACCESS_SPLIT) begin
         // Same low window as an offset from a zero pointer
         io.addr = {LOW_BANK, io.operand};
      end else begin
         io.addr = {SFR_BANK, io.operand};
      end
   end

endmodule

`default_nettype wire

// ===== logic/indexed_literal_offset_addr_decode.sv
// Functional notes
// - Extension off: operand is literal, in access bank if a=0, else in selected bank.
// - Extension on, a=0: operand 5Fh or below is an offset added to pointer two.
// - In extended mode operands above 5Fh keep their literal access-bank meaning.
// - The remap applies to every byte and bit instruction that carries the access bit.
// - With pointer two at zero, offset access hits the literal access-bank locations.
// - In both modes d=0 sends the result to the working register, d=1 to the file.
// - Enabling the extension also turns on offset addressing for standard instructions.
// - Xor-with-file XORs working register and file data and sets the N and Z flags.
//
// Purpose: File-address decode for byte and bit instructions, standard and extended
// Assumes: instr_word, file_data and working_reg are valid in the cycle instr_valid is high
// Notes:   Results appear one enabled clock after the instruction is presented

`default_nettype none

module indexed_literal_offset_addr_decode
   import addr_decode_pkg::*;
#(
   parameter int DATA_ADDR_W = ADDR_W
)(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  ext_enable,
   input  wire logic                  instr_valid,
   input  wire logic [INSTR_W-1:0]    instr_word,
   input  wire logic [BANK_W-1:0]     bank_select_register,
   input  wire logic [ADDR_W-1:0]     indirect_pointer_two,
   input  wire logic [OPER_W-1:0]     working_reg,
   input  wire logic [OPER_W-1:0]     file_data,
   output var  logic                  addr_valid,
   output var  logic [ADDR_W-1:0]     file_addr,
   output var  logic                  indexed_mode,
   output var  logic                  dest_file,
   output var  logic                  xor_valid,
   output var  logic [OPER_W-1:0]     xor_result,
   output var  logic                  flag_n,
   output var  logic                  flag_z
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (DATA_ADDR_W != ADDR_W) begin : g_bad_width
      $error("DATA_ADDR_W must equal the bank plus operand width");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              addr_valid;
      logic [ADDR_W-1:0] file_addr;
      logic              indexed;
      logic              dest_file;
      logic              xor_valid;
      logic [OPER_W-1:0] xor_result;
      logic              flag_n;
      logic              flag_z;
   } state_t;

   localparam state_t RESET_STATE = '{addr_valid: 1'b0, file_addr: ZERO_ADDR,
                                      indexed: 1'b0, dest_file: 1'b0,
                                      xor_valid: 1'b0, xor_result: ZERO_BYTE,
                                      flag_n: 1'b0, flag_z: 1'b0};

   state_t state;
   state_t next_state;

   addr_calc_if calc_bus ();

   file_addr_calc u_calc (
      .io (calc_bus)
   );

   // ----------------------------------------------------------------
   // Instruction class decode
   // ----------------------------------------------------------------
   logic                             affected;
   logic                             is_xor;
   logic [$bits(OP_FILE_FIRST)-1:0]  op_nib;
   logic [OPER_W-1:0]                xor_now;

   assign op_nib = instr_word[OP_HI -: $bits(OP_FILE_FIRST)];

   // Every opcode class carrying the access bit goes through the same path,
   // so no instruction can slip past the offset substitution
   assign affected = ((op_nib >= OP_FILE_FIRST) && (op_nib <= OP_FILE_LAST))
                     || (instr_word[OP_HI -: $bits(OP_MUL_FILE)] == OP_MUL_FILE)
                     || (instr_word[OP_HI -: $bits(OP_DEC_FILE)] == OP_DEC_FILE);
   assign is_xor   = (instr_word[OP_HI -: $bits(OP_XOR_FILE)] == OP_XOR_FILE);
   assign xor_now  = working_reg ^ file_data;

   assign calc_bus.operand    = instr_word[OPER_W-1:0];
   assign calc_bus.access_bit = instr_word[A_BIT];
   // Sampled per instruction; changing it mid-program remaps live code
   assign calc_bus.ext_enable = ext_enable;
   assign calc_bus.bank       = bank_select_register;
   assign calc_bus.pointer    = indirect_pointer_two;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (ce) begin
         next_state.addr_valid = instr_valid && affected;
         next_state.xor_valid  = instr_valid && is_xor;
         if (instr_valid && affected) begin
            next_state.file_addr = calc_bus.addr;
            next_state.indexed   = calc_bus.indexed;
            next_state.dest_file = instr_word[D_BIT];
         end
         if (instr_valid && is_xor) begin
            next_state.xor_result = xor_now;
            next_state.flag_n     = xor_now[OPER_W-1];
            next_state.flag_z     = (xor_now == ZERO_BYTE);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= RESET_STATE;
      end else begin
         state <= next_state;
      end
   end

   assign addr_valid   = state.addr_valid;
   assign file_addr    = state.file_addr;
   assign indexed_mode = state.indexed;
   assign dest_file    = state.dest_file;
   assign xor_valid    = state.xor_valid;
   assign xor_result   = state.xor_result;
   assign flag_n       = state.flag_n;
   assign flag_z       = state.flag_z;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic              hlp_low;
   logic [ADDR_W-1:0] hlp_off;

   assign hlp_low = instr_word[OPER_W-1:0] <= OFFSET_LIMIT;
   assign hlp_off = indirect_pointer_two + {ZERO_BANK, instr_word[OPER_W-1:0]};

   sequence s_issue;
      ce && instr_valid && affected;
   endsequence

   sequence s_offset_issue;
      s_issue ##0 (ext_enable && !instr_word[A_BIT] && hlp_low);
   endsequence

   a_literal_bank_sel: assert property (
      s_issue ##0 (!ext_enable && instr_word[A_BIT]) |=>
         addr_valid && !indexed_mode
         && file_addr == {$past(bank_select_register), $past(instr_word[OPER_W-1:0])})
      else $error("banked literal address wrong");

   a_offset_subst: assert property (
      s_offset_issue |=> indexed_mode && file_addr == $past(hlp_off))
      else $error("offset not added to pointer two");

   a_high_literal: assert property (
      s_issue ##0 (ext_enable && !instr_word[A_BIT] && !hlp_low) |=>
         !indexed_mode && file_addr[OPER_W-1:0] == $past(instr_word[OPER_W-1:0]))
      else $error("high operand lost literal meaning");

   a_bit_ops_indexed: assert property (
      ce && instr_valid && op_nib >= OP_BIT_FIRST && op_nib <= OP_FILE_LAST
         && ext_enable && !instr_word[A_BIT] && hlp_low |=> addr_valid && indexed_mode)
      else $error("bit instruction skipped offset mode");

   a_zero_pointer: assert property (
      s_offset_issue ##0 (indirect_pointer_two == ZERO_ADDR) |=>
         file_addr == {LOW_BANK, $past(instr_word[OPER_W-1:0])})
      else $error("zero pointer does not match access bank");

   a_dest_decode: assert property (
      s_issue |=> dest_file == $past(instr_word[D_BIT]))
      else $error("destination bit misdecoded");

   a_ext_off_plain: assert property (
      s_issue ##0 !ext_enable |=> !indexed_mode)
      else $error("offset mode without extension");

   a_xor_flags: assert property (
      ce && instr_valid && is_xor |=> xor_valid
         && xor_result == $past(working_reg ^ file_data)
         && flag_n == xor_result[OPER_W-1] && flag_z == (xor_result == ZERO_BYTE))
      else $error("xor result or flags wrong");

   a_mode_select: assert property (
      s_issue |=> indexed_mode == $past(ext_enable && !instr_word[A_BIT] && hlp_low))
      else $error("path choice ignores extension enable");

   // ----------------------------------------------------------------
   // Hold checks
   // ----------------------------------------------------------------
   // A skipped word must not disturb the address the data bus is using
   sequence s_no_file_op;
      ce && !(instr_valid && affected);
   endsequence

   a_unaffected_hold: assert property (
      s_no_file_op |=> !addr_valid && $stable(file_addr) && $stable(indexed_mode))
      else $error("address moved on an unaffected word");

   a_xor_strobe: assert property (
      ce && !(instr_valid && is_xor) |=> !xor_valid && $stable(xor_result))
      else $error("xor strobe or result moved without xor");

   a_ce_freeze: assert property (
      !ce |=> $stable(addr_valid) && $stable(file_addr) && $stable(xor_valid))
      else $error("outputs moved with clock enable low");

endmodule

`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the file-address decoder, standard and extended mode
// Assumes: Inputs driven on the falling edge, outputs sampled one falling edge later
// Notes:   Expected addresses are rebuilt here from the address map, not from the design

`default_nettype none

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import addr_decode_pkg::*;

   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                ce = 1'b1;
   logic                ext_enable = 1'b0;
   logic                instr_valid = 1'b0;
   logic [INSTR_W-1:0]  instr_word = 16'h0000;
   logic [BANK_W-1:0]   bank = 4'h3;
   logic [ADDR_W-1:0]   ptr = 12'h100;
   logic [OPER_W-1:0]   w = 8'hAF;
   logic [OPER_W-1:0]   fd = 8'hB5;
   logic                addr_valid, indexed_mode, dest_file, xor_valid, flag_n, flag_z;
   logic [ADDR_W-1:0]   file_addr;
   logic [OPER_W-1:0]   xor_result;
   int                  num_errors = 0;
   int                  total_checks = 0;
   int                  cycles = 0;

   always #50 clk = ~clk;

   indexed_literal_offset_addr_decode uut (
      .clk(clk), .rst(rst), .ce(ce), .ext_enable(ext_enable), .instr_valid(instr_valid),
      .instr_word(instr_word), .bank_select_register(bank), .indirect_pointer_two(ptr),
      .working_reg(w), .file_data(fd), .addr_valid(addr_valid), .file_addr(file_addr),
      .indexed_mode(indexed_mode), .dest_file(dest_file), .xor_valid(xor_valid),
      .xor_result(xor_result), .flag_n(flag_n), .flag_z(flag_z));

   function automatic logic [ADDR_W-1:0] exp_addr(input logic [15:0] iw, input logic e);
      if (e && !iw[A_BIT] && iw[7:0] <= OFFSET_LIMIT) return ptr + {4'h0, iw[7:0]};
      if (iw[A_BIT]) return {bank, iw[7:0]};
      if (iw[7:0] < ACCESS_SPLIT) return {LOW_BANK, iw[7:0]};
      return {SFR_BANK, iw[7:0]};
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic op(input logic [15:0] iw, input logic e);
      instr_word = iw;
      ext_enable = e;
      instr_valid = 1'b1;
      @(negedge clk);
   endtask

   task automatic chk_op(input logic [15:0] iw, input logic e);
      op(iw, e);
      `CHK("addr_valid", 1'b1, addr_valid)
      `CHK("file_addr", exp_addr(iw, e), file_addr)
      `CHK("indexed_mode", e && !iw[A_BIT] && iw[7:0] <= OFFSET_LIMIT, indexed_mode)
      `CHK("dest_file", iw[D_BIT], dest_file)
   endtask

   task automatic chk_xor(input logic [7:0] wv, input logic [7:0] fv);
      w = wv;
      fd = fv;
      chk_op(16'h1A05, 1'b1);
      `CHK("xor_valid", 1'b1, xor_valid)
      `CHK("xor_result", wv ^ fv, xor_result)
      `CHK("flag_n", (wv ^ fv) >= 8'h80, flag_n)
      `CHK("flag_z", (wv ^ fv) == 8'h00, flag_z)
   endtask

   task automatic idle();
      instr_valid = 1'b0;
      @(negedge clk);
   endtask

   initial begin
      logic [15:0] iw;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      `CHK("addr_valid rst", 1'b0, addr_valid)
      `CHK("file_addr rst", 12'h000, file_addr)
      `CHK("xor_result rst", 8'h00, xor_result)
      // Standard mode: access bank both halves and a banked access
      chk_op(16'h6005, 1'b0);
      chk_op(16'h60A0, 1'b0);
      chk_op(16'h6120, 1'b0);
      $display("test literal done");
      // Offset boundary 5Fh/60h, banked access untouched, pointer wrap
      chk_op(16'h2000, 1'b1);
      chk_op(16'h205F, 1'b1);
      chk_op(16'h2060, 1'b1);
      chk_op(16'h20A0, 1'b1);
      chk_op(16'h2105, 1'b1);
      ptr = 12'hFFF;
      chk_op(16'h2005, 1'b1);
      ptr = 12'h200;
      $display("test offset done");
      // Every file and bit class, plus the two short-opcode file forms
      for (int c = 1; c <= 11; c++) chk_op({c[3:0], 12'h010}, 1'b1);
      chk_op(16'h0210, 1'b1);
      chk_op(16'h0410, 1'b1);
      $display("test classes done");
      // Pointer at zero restores the literal low access bank
      ptr = 12'h000;
      for (int f = 0; f <= 95; f += 19) begin
         chk_op({8'h24, f[7:0]}, 1'b1);
         `CHK("remap", {LOW_BANK, f[7:0]}, file_addr)
      end
      ptr = 12'h100;
      $display("test remap done");
      // Destination bit in both modes, mode switched back to back
      for (int m = 0; m < 4; m++) begin
         chk_op({6'h09, m[1], 1'b0, 8'h30}, m[0]);
      end
      $display("test dest done");
      chk_xor(8'hAF, 8'hB5);
      chk_xor(8'hF0, 8'h0F);
      chk_xor(8'h55, 8'h55);
      $display("test xor done");
      // Unaffected words leave the last address; a plain file op gives no xor strobe
      chk_op(16'h2044, 1'b1);
      `CHK("xor_valid", 1'b0, xor_valid)
      iw = 16'h0E05;
      op(iw, 1'b1);
      `CHK("addr_valid", 1'b0, addr_valid)
      `CHK("file_addr", 12'h144, file_addr)
      op(16'hC123, 1'b1);
      `CHK("addr_valid", 1'b0, addr_valid)
      chk_op(16'h2011, 1'b0);
      // Clock enable low freezes all outputs
      ce = 1'b0;
      op(16'h2022, 1'b1);
      `CHK("addr_valid hold", 1'b1, addr_valid)
      `CHK("file_addr hold", 12'h011, file_addr)
      ce = 1'b1;
      idle();
      `CHK("addr_valid idle", 1'b0, addr_valid)
      rst = 1'b1;
      idle();
      `CHK("file_addr rst", 12'h000, file_addr)
      rst = 1'b0;
      // First instruction straight after a mid-run reset must be taken
      chk_op(16'h2005, 1'b1);
      $display("test misc done");
      summarize();
   end
endmodule

`undef CHK

`default_nettype wire
